// >>> rgbw_host_model.sv
// Host controller model: word writes and word reads on the two-wire bus
`timescale 1ns/1ps
module rgbw_host_model
  import rgbw_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        sda_line_i,
  output logic             scl_o,
  output logic             sda_oe_o,
  output logic             rd_valid_o,
  output logic      [15:0] rd_data_o
);
  initial begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    rd_valid_o = 1'b0;
    rd_data_o = 16'h0000;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // Low phase of 60 clocks leaves the target its 3-clock answer delay and keeps the run short
  task automatic bit_x(input logic b, output logic r);
    tick(30);
    sda_oe_o <= ~b;
    tick(30);
    scl_o <= 1'b1;
    tick(5);
    r = sda_line_i;
    scl_o <= 1'b0;
  endtask

  // Serves as repeated start too: released line is raised before falling
  task automatic start_c;
    tick(50);
    sda_oe_o <= 1'b0;
    tick(50);
    scl_o <= 1'b1;
    tick(10);
    sda_oe_o <= 1'b1;
    tick(10);
    scl_o <= 1'b0;
  endtask

  task automatic stop_c;
    tick(50);
    sda_oe_o <= 1'b1;
    tick(50);
    scl_o <= 1'b1;
    tick(10);
    sda_oe_o <= 1'b0;
    tick(20);
  endtask

  task automatic byte_x(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
      q[i] = r;
    end
    bit_x(ack_in, r);
    ack = ~r;
  endtask

  task automatic write_word(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d, output logic ok);
    logic [7:0] q;
    logic       a0, a1, a2, a3;
    start_c();
    byte_x({a, 1'b0}, 1'b1, q, a0);
    byte_x(c, 1'b1, q, a1);
    byte_x(d[7:0], 1'b1, q, a2);
    byte_x(d[15:8], 1'b1, q, a3);
    stop_c();
    ok = a0 & a1 & a2 & a3;
  endtask

  // Both bytes in one transfer, repeated start, no stop before it
  task automatic read_word(input logic [7:0] c);
    logic [7:0] lo, hi;
    logic       k;
    start_c();
    byte_x({TARGET_ADDR, 1'b0}, 1'b1, lo, k);
    byte_x(c, 1'b1, lo, k);
    start_c();
    byte_x({TARGET_ADDR, 1'b1}, 1'b1, lo, k);
    byte_x(8'hFF, 1'b0, lo, k);
    byte_x(8'hFF, 1'b1, hi, k);
    stop_c();
    rd_data_o <= {hi, lo};
    rd_valid_o <= 1'b1;
    tick(1);
    rd_valid_o <= 1'b0;
  endtask
endmodule

// >>> rgbw_meas_engine.sv
// Measurement sequencer: integration timing and result capture
`timescale 1ns/1ps
module rgbw_meas_engine
  import rgbw_pkg::*;
#(
  parameter int unsigned INTEG_CYCLES = INTEG_BASE_CYCLES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        sensor_shutdown_i,
  input  wire logic        forced_mode_sel_i,
  input  wire logic [2:0]  integration_time_sel_i,
  input  wire logic        one_shot_go_i,
  input  wire logic [15:0] red_count_i,
  input  wire logic [15:0] green_count_i,
  input  wire logic [15:0] blue_count_i,
  input  wire logic [15:0] white_count_i,
  output logic      [15:0] red_result_o,
  output logic      [15:0] green_result_o,
  output logic      [15:0] blue_result_o,
  output logic      [15:0] white_result_o,
  output logic             busy_o
);

  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] limit;
  logic               capture;

  // Each code step doubles the window; undefined codes clamp to the longest
  function automatic logic [TIMER_W-1:0] integ_len(input logic [2:0] code);
    logic [2:0] c;
    c = (code > IT_MAX_CODE) ? IT_MAX_CODE : code;
    return TIMER_W'(INTEG_CYCLES) << c;
  endfunction

  assign limit   = integ_len(integration_time_sel_i);
  // Greater-or-equal ends a window at once when the host shortens it mid-run, instead of wrapping the timer
  assign capture = busy_o && !sensor_shutdown_i && (timer >= limit - TIMER_W'(1));

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      timer  <= '0;
    end else if (sensor_shutdown_i) begin
      // Abort keeps the previous results intact
      busy_o <= 1'b0;
      timer  <= '0;
    end else if (busy_o) begin
      if (capture) begin
        timer  <= '0;
        busy_o <= !forced_mode_sel_i;
      end else begin
        timer <= timer + TIMER_W'(1);
      end
    end else if (!forced_mode_sel_i || one_shot_go_i) begin
      busy_o <= 1'b1;
      timer  <= '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      red_result_o   <= RESULT_RESET;
      green_result_o <= RESULT_RESET;
      blue_result_o  <= RESULT_RESET;
      white_result_o <= RESULT_RESET;
    end else if (capture) begin
      red_result_o   <= red_count_i;
      green_result_o <= green_count_i;
      blue_result_o  <= blue_count_i;
      white_result_o <= white_count_i;
    end
  end

  shut_idle_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    sensor_shutdown_i |=> !busy_o)
    else $error("engine busy after shutdown");

  forced_wait_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (forced_mode_sel_i && !busy_o && !one_shot_go_i) |=> !busy_o)
    else $error("forced mode started without trigger");

  auto_rerun_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (capture && !forced_mode_sel_i) |=> (busy_o && timer == '0))
    else $error("auto mode did not restart");

  results_hold_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !capture |=> ($stable(red_result_o) && $stable(green_result_o) && $stable(blue_result_o)
                  && $stable(white_result_o)))
    else $error("results changed without a measurement");

  integ_len_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (integration_time_sel_i == 3'h5) |-> (limit == (TIMER_W'(INTEG_CYCLES) << 5)))
    else $error("1280 ms window wrong length");

  auto_capture_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    capture && !forced_mode_sel_i);

  forced_capture_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    capture && forced_mode_sel_i ##1 !busy_o);

endmodule

// >>> rgbw_pkg.sv
// Shared constants and types of the RGBW sensor register block
package rgbw_pkg;

  // Bus target address and command codes
  localparam logic [6:0] TARGET_ADDR    = 7'h10;
  localparam logic [7:0] CMD_CONFIG     = 8'h00;
  localparam logic [7:0] CMD_RESV_FIRST = 8'h01;
  localparam logic [7:0] CMD_RESV_LAST  = 8'h07;
  localparam logic [7:0] CMD_RED        = 8'h08;
  localparam logic [7:0] CMD_GREEN      = 8'h09;
  localparam logic [7:0] CMD_BLUE       = 8'h0A;
  localparam logic [7:0] CMD_WHITE      = 8'h0B;

  // Field positions in the configuration low byte
  localparam int unsigned CFG_SD_POS   = 0;
  localparam int unsigned CFG_AF_POS   = 1;
  localparam int unsigned CFG_ONE_SHOT_REQUEST_POS = 2;
  localparam int unsigned CFG_IT_LSB   = 4;
  localparam int unsigned CFG_IT_MSB   = 6;

  // Values after reset
  localparam logic [2:0]  IT_RESET     = 3'h0;
  localparam logic        AF_RESET     = 1'b0;
  localparam logic        ONE_SHOT_REQUEST_RESET   = 1'b0;
  localparam logic        SD_RESET     = 1'b0;
  localparam logic [7:0]  RESV_VALUE   = 8'h00;
  localparam logic [15:0] RESULT_RESET = 16'h0000;

  // Largest defined integration code (1280 ms)
  localparam logic [2:0] IT_MAX_CODE = 3'h5;

  // Timing: shortest integration time and clock rate
  localparam int unsigned CLK_FREQ_KHZ      = 100_000;
  localparam int unsigned INTEG_BASE_MS     = 40;
  localparam int unsigned INTEG_BASE_CYCLES = INTEG_BASE_MS * CLK_FREQ_KHZ;
  localparam int unsigned TIMER_W           = 28;

  // Bit counter values
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_ADDR,
    ST_ADDR_ACK,
    ST_CMD,
    ST_CMD_ACK,
    ST_WR_DATA,
    ST_WR_ACK,
    ST_RD_DATA,
    ST_RD_ACK
  } rgbw_state_t;

endpackage

// >>> rgbw_sensor_regs.sv
// Bus target, configuration register and result readout of the RGBW sensor
// Function
// - 16-bit config register, low byte then high
// - Integration code 0..5 selects 40..1280 ms
// - Mode bit: 0 auto, 1 host forced
// - Forced mode: trigger write starts one cycle
// - Shutdown bit 1 disables sensing
// - Bits 7, 3 and high byte read zero
// - Commands 01h-07h reserved, read 0x00
// - Commands 08h-0Bh return red, green, blue, white
// - Low byte carries LSB, high byte MSB
// - Results held until next measurement completes
// - Answer at 7-bit target address 10h
`timescale 1ns/1ps
module rgbw_sensor_regs
  import rgbw_pkg::*;
#(
  parameter int unsigned INTEG_CYCLES = INTEG_BASE_CYCLES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  input  wire logic [15:0] red_count_i,
  input  wire logic [15:0] green_count_i,
  input  wire logic [15:0] blue_count_i,
  input  wire logic [15:0] white_count_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             sensing_enable_o,
  output logic             integrating_o
);

  logic        scl_s1;
  logic        scl_s2;
  logic        scl_s3;
  logic        sda_s1;
  logic        sda_s2;
  logic        sda_s3;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;

  rgbw_state_t state;
  logic [3:0]  bit_cnt;
  logic [7:0]  rx_shift;
  logic [7:0]  tx_shift;
  logic [7:0]  cmd;
  logic        read_dir;
  logic        byte_hi;
  logic [7:0]  wr_lo;
  logic        host_nack;

  logic [2:0]  integration_time_sel;
  logic        one_shot_request;
  logic        forced_mode_sel;
  logic        sensor_shutdown;
  logic        one_shot_go;

  logic [15:0] red_result;
  logic [15:0] green_result;
  logic [15:0] blue_result;
  logic [15:0] white_result;
  logic        busy;

  logic [15:0] rd_word;
  logic        wr_commit;
  logic [15:0] wr_word;
  logic        tx_load;
  logic        tx_hi;
  logic [7:0]  tx_byte;

  function automatic logic [7:0] pick_byte(input logic [15:0] word, input logic hi);
    return hi ? word[15:8] : word[7:0];
  endfunction

  // Pins are asynchronous to ref_clk_i; edges are taken from stages two and three
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  assign scl_rise  = scl_s2 && !scl_s3;
  assign scl_fall  = !scl_s2 && scl_s3;
  assign bus_start = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign bus_stop  = scl_s2 && scl_s3 && !sda_s3 && sda_s2;

  // Register read view; reserved bits and codes read as zero
  always_comb begin
    case (cmd)
      CMD_CONFIG: rd_word = {RESV_VALUE, 1'b0, integration_time_sel, 1'b0,
                             one_shot_request, forced_mode_sel, sensor_shutdown};
      CMD_RED:    rd_word = red_result;
      CMD_GREEN:  rd_word = green_result;
      CMD_BLUE:   rd_word = blue_result;
      CMD_WHITE:  rd_word = white_result;
      default:    rd_word = {RESV_VALUE, RESV_VALUE};
    endcase
  end

  // Next byte to shift out: first byte after address is low, then alternate
  assign tx_load = scl_fall && !bus_start && !bus_stop &&
                   ((state == ST_ADDR_ACK && read_dir) || (state == ST_RD_ACK && !host_nack));
  assign tx_hi   = (state == ST_RD_ACK) ? !byte_hi : 1'b0;
  assign tx_byte = pick_byte(rd_word, tx_hi);

  assign wr_commit = scl_fall && !bus_start && !bus_stop && state == ST_WR_DATA &&
                     bit_cnt == BITS_PER_BYTE && byte_hi;
  assign wr_word   = {rx_shift, wr_lo};

  // Target protocol sequencer
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state     <= ST_IDLE;
      bit_cnt   <= BIT_CNT_RESET;
      rx_shift  <= 8'h00;
      tx_shift  <= 8'h00;
      cmd       <= CMD_CONFIG;
      read_dir  <= 1'b0;
      byte_hi   <= 1'b0;
      wr_lo     <= 8'h00;
      host_nack <= 1'b0;
      sda_oe_o  <= 1'b0;
    end else if (bus_start) begin
      state    <= ST_ADDR;
      bit_cnt  <= BIT_CNT_RESET;
      sda_oe_o <= 1'b0;
    end else if (bus_stop) begin
      state    <= ST_IDLE;
      sda_oe_o <= 1'b0;
    end else if (scl_rise) begin
      case (state)
        ST_ADDR, ST_CMD, ST_WR_DATA: begin
          rx_shift <= {rx_shift[6:0], sda_s2};
          bit_cnt  <= bit_cnt + 4'h1;
        end
        ST_RD_DATA: begin
          bit_cnt <= bit_cnt + 4'h1;
        end
        ST_RD_ACK: begin
          host_nack <= sda_s2;
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (state)
        ST_ADDR: begin
          if (bit_cnt == BITS_PER_BYTE) begin
            if (rx_shift[7:1] == TARGET_ADDR) begin
              state    <= ST_ADDR_ACK;
              read_dir <= rx_shift[0];
              sda_oe_o <= 1'b1;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          bit_cnt <= BIT_CNT_RESET;
          if (read_dir) begin
            // Read resumes at the command latched by the preceding write phase
            state    <= ST_RD_DATA;
            byte_hi  <= 1'b0;
            tx_shift <= {tx_byte[6:0], 1'b0};
            sda_oe_o <= !tx_byte[7];
          end else begin
            state    <= ST_CMD;
            sda_oe_o <= 1'b0;
          end
        end
        ST_CMD: begin
          if (bit_cnt == BITS_PER_BYTE) begin
            state    <= ST_CMD_ACK;
            cmd      <= rx_shift;
            byte_hi  <= 1'b0;
            sda_oe_o <= 1'b1;
          end
        end
        ST_CMD_ACK: begin
          state    <= ST_WR_DATA;
          bit_cnt  <= BIT_CNT_RESET;
          sda_oe_o <= 1'b0;
        end
        ST_WR_DATA: begin
          if (bit_cnt == BITS_PER_BYTE) begin
            state    <= ST_WR_ACK;
            sda_oe_o <= 1'b1;
            if (!byte_hi) begin
              wr_lo <= rx_shift;
            end
          end
        end
        ST_WR_ACK: begin
          state    <= ST_WR_DATA;
          bit_cnt  <= BIT_CNT_RESET;
          byte_hi  <= !byte_hi;
          sda_oe_o <= 1'b0;
        end
        ST_RD_DATA: begin
          if (bit_cnt == BITS_PER_BYTE) begin
            state    <= ST_RD_ACK;
            sda_oe_o <= 1'b0;
          end else begin
            tx_shift <= {tx_shift[6:0], 1'b0};
            sda_oe_o <= !tx_shift[7];
          end
        end
        ST_RD_ACK: begin
          if (host_nack) begin
            state    <= ST_IDLE;
            sda_oe_o <= 1'b0;
          end else begin
            // A word read that goes on wraps between the two bytes
            state    <= ST_RD_DATA;
            bit_cnt  <= BIT_CNT_RESET;
            byte_hi  <= !byte_hi;
            tx_shift <= {tx_byte[6:0], 1'b0};
            sda_oe_o <= !tx_byte[7];
          end
        end
        default: begin
          state    <= ST_IDLE;
          sda_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // Configuration register; writes to reserved or result codes are dropped
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      integration_time_sel <= IT_RESET;
      one_shot_request     <= ONE_SHOT_REQUEST_RESET;
      forced_mode_sel      <= AF_RESET;
      sensor_shutdown      <= SD_RESET;
    end else if (wr_commit && cmd == CMD_CONFIG) begin
      integration_time_sel <= wr_word[CFG_IT_MSB:CFG_IT_LSB];
      one_shot_request     <= wr_word[CFG_ONE_SHOT_REQUEST_POS];
      forced_mode_sel      <= wr_word[CFG_AF_POS];
      sensor_shutdown      <= wr_word[CFG_SD_POS];
    end
  end

  // Single-cycle start request, only when the same write selects forced mode
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      one_shot_go <= 1'b0;
    end else begin
      one_shot_go <= wr_commit && cmd == CMD_CONFIG && wr_word[CFG_ONE_SHOT_REQUEST_POS] &&
                     wr_word[CFG_AF_POS];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_o            <= 1'b0;
      sensing_enable_o <= 1'b0;
      integrating_o    <= 1'b0;
    end else begin
      sda_o            <= 1'b0; // Open drain: the line is only ever pulled low
      sensing_enable_o <= !sensor_shutdown;
      integrating_o    <= busy;
    end
  end

  rgbw_meas_engine #(
    .INTEG_CYCLES (INTEG_CYCLES)
  ) u_engine (
    .ref_clk_i              (ref_clk_i),
    .rst_n_i                (rst_n_i),
    .sensor_shutdown_i      (sensor_shutdown),
    .forced_mode_sel_i      (forced_mode_sel),
    .integration_time_sel_i (integration_time_sel),
    .one_shot_go_i          (one_shot_go),
    .red_count_i            (red_count_i),
    .green_count_i          (green_count_i),
    .blue_count_i           (blue_count_i),
    .white_count_i          (white_count_i),
    .red_result_o           (red_result),
    .green_result_o         (green_result),
    .blue_result_o          (blue_result),
    .white_result_o         (white_result),
    .busy_o                 (busy)
  );

  addr_ack_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state == ST_ADDR_ACK) |-> (sda_oe_o && $past(rx_shift[7:1], 2) == TARGET_ADDR))
    else $error("address acknowledged without match");
  cfg_write_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (wr_commit && cmd == CMD_CONFIG) |=> (integration_time_sel == $past(wr_word[6:4]) &&
                                          sensor_shutdown == $past(wr_word[0])))
    else $error("configuration word not stored");
  one_shot_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    one_shot_go |=> (!one_shot_go && forced_mode_sel))
    else $error("trigger not a single pulse in forced mode");
  // A zero bit is sent by pulling the line, so a zero byte keeps the driver on
  resv_read_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (tx_load && cmd >= CMD_RESV_FIRST && cmd <= CMD_RESV_LAST) |=> (sda_oe_o && tx_shift == 8'h00))
    else $error("reserved code read not zero");
  cfg_zero_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (cmd == CMD_CONFIG) |-> (rd_word[15:8] == 8'h00 && !rd_word[7] && !rd_word[3]))
    else $error("reserved configuration bits not zero");
  byte_order_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (tx_load && cmd == CMD_RED) |=> (tx_shift == {$past(tx_hi ? red_result[14:8] : red_result[6:0]), 1'b0}))
    else $error("result byte order wrong");

  word_read_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    (state == ST_RD_ACK && byte_hi && host_nack && scl_fall));
  cfg_write_c: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    wr_commit && cmd == CMD_CONFIG);

endmodule

// >>> rgbw_sensor_regs_tb_top.sv
// Self-checking bench: register access, window timing and result retention
`timescale 1ns/1ps
module rgbw_sensor_regs_tb_top
  import rgbw_pkg::*;
;
  localparam int unsigned IC = 8;
  logic              ref_clk_i;
  logic              rst_n_i;
  logic              scl;
  logic              host_oe;
  logic              dev_oe;
  logic              sda_o;
  logic              sens_en;
  logic              integ;
  logic              rd_valid;
  logic              ok;
  logic              strict = 1'b0;
  logic       [15:0] rd_data;
  logic       [15:0] keep;
  logic       [15:0] cnt [4];
  logic       [15:0] rd_q [$];
  int unsigned       w_q [$];
  int                miscompares = 0;
  int                n_compared = 0;
  int                width = 0;
  int                cycles = 0;
  integer            seed = 32'hC980;
  wire               sda_line = (dev_oe ? sda_o : 1'b1) & ~host_oe;

  rgbw_sensor_regs #(.INTEG_CYCLES(IC)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_line),
    .red_count_i(cnt[0]), .green_count_i(cnt[1]), .blue_count_i(cnt[2]), .white_count_i(cnt[3]),
    .sda_o(sda_o), .sda_oe_o(dev_oe), .sensing_enable_o(sens_en), .integrating_o(integ));

  rgbw_host_model i_host (
    .ref_clk_i(ref_clk_i), .sda_line_i(sda_line), .scl_o(scl), .sda_oe_o(host_oe),
    .rd_valid_o(rd_valid), .rd_data_o(rd_data));

  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic end_sim;
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    rd_q.push_back(e);
    i_host.read_word(c);
  endtask

  // A nonzero w notes the window length that the write must launch
  task automatic wr(input logic [15:0] d, input int unsigned w);
    if (w != 0)
      w_q.push_back(w);
    i_host.write_word(TARGET_ADDR, CMD_CONFIG, d, ok);
    check({15'h0000, ok}, 16'h0001, "write ack");
  endtask

  task automatic new_counts;
    @(posedge ref_clk_i);
    foreach (cnt[i]) cnt[i] <= 16'($random(seed));
  endtask

  always @(posedge ref_clk_i) begin
    if (rd_valid === 1'b1 && rd_q.size() > 0)
      check(rd_data, rd_q.pop_front(), "read word");
  end

  // Once forced mode is settled, every window must have been asked for
  always @(posedge ref_clk_i) begin
    if (integ === 1'b1)
      width++;
    else if (width != 0) begin
      if (w_q.size() > 0)
        check(16'(width), 16'(w_q.pop_front()), "window length");
      else if (strict)
        check(16'(width), 16'h0000, "unrequested window");
      width = 0;
    end
  end

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      miscompares++;
      $display("Error at %0t: run did not finish in time", $time);
      end_sim();
    end
  end

  initial begin
    rst_n_i = 1'b0;
    foreach (cnt[i]) cnt[i] = 16'($random(seed));
    repeat (3) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (40) @(posedge ref_clk_i);
    rd(CMD_CONFIG, 16'h0000);                                          // Defaults
    for (int i = 0; i < 4; i++) rd(CMD_RED + 8'(i), cnt[i]);           // Auto results
    for (int c = CMD_RESV_FIRST; c <= CMD_RESV_LAST; c++) rd(8'(c), 16'h0000); // Reserved
    wr(16'h0002, 0);                                                   // Forced, no trigger
    repeat (20) @(posedge ref_clk_i);
    strict <= 1'b1;
    new_counts();
    for (int it = 0; it < 8; it++) wr(16'(it << 4) | 16'h0006, IC << (it > 5 ? 5 : it));
    wait (integ === 1'b0);                                             // Last window captured
    keep = cnt[1];
    new_counts();
    rd(CMD_GREEN, keep);                                               // Updated then held
    i_host.write_word(7'h11, CMD_CONFIG, 16'h0001, ok);
    check({15'h0000, ok}, 16'h0000, "foreign address ack");            // Not addressed
    check({15'h0000, sens_en}, 16'h0001, "sensing on");                // Enabled
    wr(16'h0053, 0);
    check({15'h0000, sens_en}, 16'h0000, "sensing off");               // Shut down
    rd(CMD_CONFIG, 16'h0053);                                          // Word readback
    repeat (20) @(posedge ref_clk_i);
    end_sim();
  end
endmodule
